// >>> inc/seeprm_defines.vh
// constants and timing counts for the serial eeprom slave
// How it works
// - stop ending a write starts the internal programming cycle at once.
// - while programming runs, own slave address gets not-acknowledge.
// - after programming ends, slave address is acknowledged again.
// - direction bit one means read of byte at current pointer.
// - after read address ack, shift byte out, release line, sample master ack.
// - not-acknowledge then stop ends the read and returns to standby.
// - after repeated start read address is acked, loaded address byte is sent.
// - each master acknowledge makes the next consecutive byte go out.
// - read pointer counts over whole array, wraps only at last location.
// - reset holds the bus ignored; release enters standby.
// - array starts with every byte all ones.
// - slave address: fixed type prefix, three strap or upper bits, direction.
// - ack by pulling data low in ninth clock; release it when reading.
// - page write buffers sixteen bytes, low four bits wrap within page.
`ifndef SEEPRM_DEFINES_VH
`define SEEPRM_DEFINES_VH
// device-type prefix: arbitrary value, not the code of any real part
`define SEEPRM_TYPE_PREFIX 4'h5
`define SEEPRM_ERASED      8'hFF
`define SEEPRM_PAGE_BITS   4
`define SEEPRM_CLK_MHZ     40
`define SEEPRM_TWR_US      5000
`define SEEPRM_TWR_CYC     (`SEEPRM_TWR_US * `SEEPRM_CLK_MHZ)
`define SEEPRM_FIFO_W      8
`define SEEPRM_FIFO_D      8
`endif

// >>> hdl/seeprm_fifo.v
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module seeprm_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         clr,
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid,
  input  wire         out_ready
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rp_r];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (clr) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      if (push && !pop) cnt_r <= cnt_r + 1'b1;
      else if (pop && !push) cnt_r <= cnt_r - 1'b1;
    end
  end
  always @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule // seeprm_fifo
`default_nettype wire

// >>> hdl/seeprm_top.v
// two-wire eeprom slave: addressing, page write, reads and ack polling
`timescale 1ns/1ps
`default_nettype none
`include "seeprm_defines.vh"
module seeprm_top #(
  parameter AB = 11,
  parameter TWR_CYC = `SEEPRM_TWR_CYC
) (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_n,
  input  wire [2:0] strap_select_inputs,
  output reg        busy
);
  localparam NB = 1 << AB;
  localparam S_IDLE = 7'h01;
  localparam S_DEV  = 7'h02;
  localparam S_ADR  = 7'h04;
  localparam S_WDAT = 7'h08;
  localparam S_RDAT = 7'h10;
  localparam S_MACK = 7'h20;
  localparam S_IGN  = 7'h40;
  localparam UB = AB - 8;

  reg [7:0] mem_r [0:NB-1];
  reg [2:0] scl_s_r;
  reg [2:0] sda_s_r;
  reg       scl_q_r;
  reg       sda_q_r;
  reg [6:0] st_r;
  reg [3:0] bit_r;
  reg [7:0] sh_r;
  reg       rd_r;
  reg       ackph_r;
  reg       wrpend_r;
  reg [AB-1:0] ptr_r;
  reg [AB-1:0] pbase_r;
  reg [31:0] twr_r;
  reg [7:0]  pg_r [0:15];
  reg [15:0] pgv_r;
  reg [3:0]  npop_r;
  integer i;

  // filtered levels: second and third stage must agree
  wire scl_f = (scl_s_r[2] == scl_s_r[1]) ? scl_s_r[1] : scl_q_r;
  wire sda_f = (sda_s_r[2] == sda_s_r[1]) ? sda_s_r[1] : sda_q_r;
  wire scl_rise = scl_f && !scl_q_r;
  wire scl_fall = !scl_f && scl_q_r;
  wire start_c = scl_f && scl_q_r && !sda_f && sda_q_r;
  wire stop_c  = scl_f && scl_q_r && sda_f && !sda_q_r;
  wire wr_go   = stop_c && st_r == S_WDAT && wrpend_r && !busy;
  wire [3:0] pg_ix = pbase_r[3:0] + npop_r;

  // strap compare: bits that are array address in this size are don't-care
  function strap_ok;
    input [2:0] got;
    input [2:0] pin;
    integer k;
    begin
      strap_ok = 1'b1;
      for (k = 0; k < 3; k = k + 1)
        if (k >= UB && got[k] != pin[k]) strap_ok = 1'b0;
    end
  endfunction

  function [AB-1:0] page_inc;
    input [AB-1:0] a;
    begin
      page_inc = {a[AB-1:`SEEPRM_PAGE_BITS], a[`SEEPRM_PAGE_BITS-1:0] + 4'h1};
    end
  endfunction

  wire [7:0] f_data;
  wire       f_valid;
  wire       f_in_ready;
  reg        f_pop;
  reg        f_push;

  // bytes pass the fifo into a sixteen-entry page buffer; the array waits for the stop
  seeprm_fifo #(.W(`SEEPRM_FIFO_W), .D(`SEEPRM_FIFO_D), .AW(3)) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n),
    .clr       (start_c),
    .in_data   (sh_r),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  always @* begin
    f_push = 1'b0;
    f_pop  = f_valid;
    if (st_r == S_WDAT && scl_fall && bit_r == 4'd8 && !ackph_r && f_in_ready)
      f_push = 1'b1;
  end

  // array: erased at reset; a page lands only when its stop starts the cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < NB; i = i + 1)
        mem_r[i] <= `SEEPRM_ERASED;
      pgv_r  <= 16'h0000;
      npop_r <= 4'h0;
    end else if (start_c) begin
      pgv_r  <= 16'h0000;
      npop_r <= 4'h0;
    end else if (wr_go) begin
      for (i = 0; i < 16; i = i + 1)
        if (pgv_r[i]) mem_r[{pbase_r[AB-1:4], i[3:0]}] <= pg_r[i];
      pgv_r <= 16'h0000;
    end else if (f_pop) begin
      pgv_r[pg_ix] <= 1'b1;
      npop_r       <= npop_r + 4'h1;
    end
  end

  // more than sixteen bytes wrap the index and overwrite earlier entries
  always @(posedge core_clk) begin
    if (f_pop) pg_r[pg_ix] <= f_data;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_r <= 3'b111;
      sda_s_r <= 3'b111;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= S_IDLE;
      bit_r    <= 4'd0;
      sh_r     <= 8'h00;
      rd_r     <= 1'b0;
      ackph_r  <= 1'b0;
      wrpend_r <= 1'b0;
      ptr_r    <= {AB{1'b0}};
      pbase_r  <= {AB{1'b0}};
      twr_r    <= 32'd0;
      busy     <= 1'b0;
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      if (busy) begin
        if (twr_r == 32'd1)
          busy <= 1'b0;
        twr_r <= twr_r - 32'd1;
      end
      if (stop_c) begin
        st_r     <= S_IDLE;
        sda_oe_n <= 1'b1;
        if (wr_go) begin
          busy  <= 1'b1;
          twr_r <= TWR_CYC;
        end
        wrpend_r <= 1'b0;
      end else if (start_c) begin
        st_r     <= busy ? S_IGN : S_DEV;
        bit_r    <= 4'd0;
        ackph_r  <= 1'b0;
        wrpend_r <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (scl_rise && !ackph_r && (st_r & (S_DEV | S_ADR | S_WDAT)) != 7'h00) begin
        sh_r  <= {sh_r[6:0], sda_f};
        bit_r <= bit_r + 4'd1;
      end else if (scl_rise && st_r == S_MACK) begin
        // the next fall must load a fresh byte, not close this one again
        bit_r <= 4'd0;
        if (sda_f) st_r <= S_IGN;
        else st_r <= S_RDAT;
      end else if (scl_fall) begin
        case (st_r)
          S_DEV: begin
            if (ackph_r) begin
              ackph_r  <= 1'b0;
              bit_r    <= 4'd0;
              sda_oe_n <= 1'b1;
              if (rd_r) begin
                st_r     <= S_RDAT;
                sh_r     <= mem_r[ptr_r];
                sda_out  <= mem_r[ptr_r][7];
                sda_oe_n <= mem_r[ptr_r][7];
                bit_r    <= 4'd1;
              end else begin
                st_r <= S_ADR;
              end
            end else if (bit_r == 4'd8) begin
              if (sh_r[7:4] == `SEEPRM_TYPE_PREFIX && strap_ok(sh_r[3:1], strap_select_inputs)) begin
                ackph_r  <= 1'b1;
                sda_out  <= 1'b0;
                sda_oe_n <= 1'b0;
                rd_r     <= sh_r[0];
                if (UB > 0) ptr_r[AB-1:8] <= sh_r[UB:1];
              end else begin
                st_r <= S_IGN;
              end
            end
          end
          S_ADR, S_WDAT: begin
            if (ackph_r) begin
              ackph_r  <= 1'b0;
              bit_r    <= 4'd0;
              sda_oe_n <= 1'b1;
              if (st_r == S_ADR) st_r <= S_WDAT;
            end else if (bit_r == 4'd8) begin
              ackph_r  <= 1'b1;
              sda_out  <= 1'b0;
              sda_oe_n <= 1'b0;
              if (st_r == S_ADR) begin
                ptr_r[7:0] <= sh_r;
                pbase_r <= {ptr_r[AB-1:8], sh_r};
              end else begin
                wrpend_r <= 1'b1;
                ptr_r    <= page_inc(ptr_r);
              end
            end
          end
          S_RDAT: begin
            if (bit_r == 4'd8) begin
              sda_oe_n <= 1'b1;
              st_r     <= S_MACK;
              ptr_r    <= ptr_r + 1'b1;
            end else if (bit_r == 4'd0) begin
              sh_r     <= mem_r[ptr_r];
              sda_out  <= mem_r[ptr_r][7];
              sda_oe_n <= mem_r[ptr_r][7];
              bit_r    <= 4'd1;
            end else begin
              sda_out  <= sh_r[7 - bit_r[2:0]];
              sda_oe_n <= sh_r[7 - bit_r[2:0]];
              bit_r    <= bit_r + 4'd1;
            end
          end
          S_MACK: bit_r <= 4'd0;
          S_IGN, S_IDLE: sda_oe_n <= 1'b1;
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule // seeprm_top
`default_nettype wire

// >>> tb/seeprm_chk.sv
// pin-level assertions for the eeprom slave
`timescale 1ns/1ps
`default_nettype none
module seeprm_chk #(
  parameter TWR_CYC = 50
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  int cnt_r;
  // length of the current programming cycle
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      cnt_r <= 0;
    else
      cnt_r <= busy ? cnt_r + 1 : 0;
  end
  sequence s_quiet;
    sda_oe_n [*3];
  endsequence
  sequence s_hold;
    $stable(sda_oe_n) [*3];
  endsequence
  property p_drive_low;
    !sda_oe_n |-> !sda_out;
  endproperty
  property p_busy_quiet;
    busy |-> sda_oe_n;
  endproperty
  property p_busy_stop;
    $rose(busy) |-> $past(scl_in, 2) && $past(sda_in, 2);
  endproperty
  property p_busy_len;
    $fell(busy) |-> cnt_r == TWR_CYC;
  endproperty
  property p_busy_max;
    busy |-> cnt_r < TWR_CYC;
  endproperty
  // the line only moves after a clock fall, so never late in the high phase
  property p_chg_low;
    $changed(sda_oe_n) |-> !$past(scl_in, 2);
  endproperty
  property p_hold_high;
    $rose(scl_in) |-> ##2 s_hold;
  endproperty
  property p_rst_idle;
    $rose(rst_n) |-> !busy ##0 s_quiet;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("data driven high");
  a_busy_quiet: assert property (p_busy_quiet) else $error("answer while busy");
  a_busy_stop: assert property (p_busy_stop) else $error("cycle not at stop");
  a_busy_len: assert property (p_busy_len) else $error("cycle too short");
  a_busy_max: assert property (p_busy_max) else $error("cycle too long");
  a_chg_low: assert property (p_chg_low) else $error("change in high phase");
  a_hold_high: assert property (p_hold_high) else $error("unstable in high");
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
endmodule // seeprm_chk
bind seeprm_top seeprm_chk #(.TWR_CYC(TWR_CYC)) u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .busy(busy));
`default_nettype wire

// >>> tb/seeprm_master.sv
// two-wire bus master model, idles with clock and data high
`timescale 1ns/1ps
`default_nettype none
module seeprm_master (
  input  wire logic core_clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_o
);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // a quarter of the 200 ns bit
  task automatic ph(input logic c, input logic d);
    scl <= c;
    sda_o <= d;
    w(2);
  endtask
  // d=0 start or repeated start, d=1 stop; data moves with clock high
  task automatic cond(input logic d);
    ph(1'b0, sda_o);
    ph(1'b0, ~d);
    ph(1'b1, ~d);
    ph(1'b1, d);
    ph(1'b1, d);
  endtask
  // nine bits msb first, sampled at the end of each high phase
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      ph(1'b0, sda_o);
      ph(1'b0, tx[i]);
      ph(1'b1, tx[i]);
      ph(1'b1, tx[i]);
      rx[i] = sda;
    end
  endtask
endmodule // seeprm_master
`default_nettype wire

// >>> tb/seeprm_tb.sv
// self-checking bench: reads, ack polling, wrap and reset
`timescale 1ns/1ps
`default_nettype none
`include "seeprm_defines.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module serial_eeprom_read_and_poll_tb;
  logic       core_clk;
  logic       rst_n;
  logic [2:0] strap_r;
  logic [8:0] rx;
  logic       scl, sda_o, sda_out, sda_oe_n, busy;
  wire        sda;
  int         n_fail = 0;
  int         total_checks = 0;
  // pull-up: low only while a party pulls it
  assign sda = sda_o & (sda_oe_n | sda_out);
  seeprm_top #(.AB(11), .TWR_CYC(300)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .strap_select_inputs(strap_r), .busy(busy));
  seeprm_master m (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_o(sda_o));
  function automatic logic [8:0] sa(input logic [10:0] a, input logic r);
    return {`SEEPRM_TYPE_PREFIX, a[10:8], r, 1'b1};
  endfunction
  task automatic tx(input logic [8:0] v, input logic ack);
    m.xfer(v, rx);
    `CHK(rx[0], ack)
  endtask
  task automatic rd(input logic [7:0] e, input logic last);
    m.xfer({8'hFF, last}, rx);
    `CHK(rx[8:1], e)
  endtask
  task automatic seladdr(input logic [10:0] a);
    m.cond(1'b0);
    tx(sa(a, 1'b0), 1'b0);
    tx({a[7:0], 1'b1}, 1'b0);
    m.cond(1'b0);
    tx(sa(a, 1'b1), 1'b0);
  endtask
  task automatic t_erased();
    m.cond(1'b0);
    tx(sa(11'h000, 1'b1), 1'b0);
    rd(8'hFF, 1'b0);
    rd(8'hFF, 1'b1);
    m.cond(1'b1);
    `CHK(sda_oe_n, 1'b1)
  endtask
  task automatic t_page_poll();
    m.cond(1'b0);
    tx(sa(11'h7FF, 1'b0), 1'b0);
    tx(9'h1FF, 1'b0);
    tx({8'h3C, 1'b1}, 1'b0);
    tx({8'hA5, 1'b1}, 1'b0);
    tx({8'h96, 1'b1}, 1'b0);
    m.cond(1'b1);
    m.cond(1'b0);
    tx(sa(11'h000, 1'b0), 1'b1);
    m.cond(1'b1);
    // bounded polling; the programming count is cut down for the run
    for (int i = 0; i < 8 && rx[0] !== 1'b0; i++) begin
      m.cond(1'b0);
      m.xfer(sa(11'h000, 1'b0), rx);
      m.cond(1'b1);
    end
    `CHK(rx[0], 1'b0)
  endtask
  task automatic t_wrap();
    // all three slave bits are array address here, so the straps must not matter
    strap_r <= 3'h5;
    seladdr(11'h7FF);
    rd(8'h3C, 1'b0);
    rd(8'hFF, 1'b1);
    m.cond(1'b1);
    seladdr(11'h7F0);
    rd(8'hA5, 1'b1);
    m.cond(1'b1);
    m.cond(1'b0);
    tx(sa(11'h7F1, 1'b1), 1'b0);
    rd(8'h96, 1'b1);
    m.cond(1'b1);
  endtask
  task automatic t_refuse_reset();
    m.cond(1'b0);
    tx({`SEEPRM_TYPE_PREFIX ^ 4'h1, 5'h01}, 1'b1);
    m.cond(1'b1);
    m.cond(1'b0);
    tx(sa(11'h000, 1'b0), 1'b0);
    tx(9'h001, 1'b0);
    tx(9'h023, 1'b0);
    m.cond(1'b1);
    m.w(4);
    `CHK(busy, 1'b1)
    rst_n <= 1'b0;
    m.w(2);
    `CHK({busy, sda_oe_n}, 2'b01)
    rst_n <= 1'b1;
    strap_r <= 3'h2;
    m.w(4);
    seladdr(11'h000);
    rd(8'hFF, 1'b1);
    m.cond(1'b1);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    strap_r = 3'h0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    m.w(4);
    t_erased();
    t_page_poll();
    t_wrap();
    t_refuse_reset();
    finish_test();
  end
  // the sequence needs a few thousand clocks; this is ample
  initial begin
    #500_000;
    n_fail++;
    finish_test();
  end
endmodule // serial_eeprom_read_and_poll_tb
`default_nettype wire
